// [include/mixer_regs_pkg.sv]
// register map, field layout and carrier types of the mixer control bank
package mixer_regs_pkg;

  // serial frame layout: read flag, 7-bit address, 16-bit data
  localparam int             FRAME_BITS    = 24;
  localparam int             ADDR_W        = 7;
  localparam int             DATA_W        = 16;
  localparam logic [4:0]     ADDR_LAST_BIT = 5'h07;
  localparam logic [4:0]     DATA_LAST_BIT = 5'h17;
  localparam int             READ_FLAG_POS = 6;

  // writable registers held in the bank
  localparam int             NUM_REGS      = 14;
  localparam int             IDX_FRAC_MOD  = 0;
  localparam int             IDX_OUT_B     = 1;
  localparam int             IDX_SYNC_MASK = 2;
  localparam int             IDX_LOCK_KIND = 3;
  localparam int             IDX_SETTLE_HI = 4;
  localparam int             IDX_SETTLE_LO = 5;
  localparam int             IDX_CH_DIV    = 6;
  localparam int             IDX_WARM      = 7;
  localparam int             IDX_CHAIN     = 8;
  localparam int             IDX_LO_ROUTE  = 9;
  localparam int             IDX_LO_CLK    = 10;
  localparam int             IDX_EXT_DIV   = 11;
  localparam int             IDX_IF_BIAS   = 12;
  localparam int             IDX_OFS_CTRL  = 13;

  localparam logic [6:0] REG_ADDR [NUM_REGS] = '{
    7'h2C, 7'h2E, 7'h3A, 7'h3B, 7'h45, 7'h46, 7'h4B,
    7'h4E, 7'h4F, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54};
  // writable bits; all others are reserved and read zero
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h0027, 16'h0003, 16'h8000, 16'h0001, 16'hFFFF, 16'hFFFF, 16'h07C0,
    16'h0200, 16'h7047, 16'h0E3F, 16'h0FF7, 16'h003F, 16'hFE00, 16'hFFC3};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'h0022, 16'h0001, 16'h8000, 16'h0001, 16'h0000, 16'hC350, 16'h0000,
    16'h0000, 16'h7000, 16'h000A, 16'h0000, 16'h0023, 16'h2000, 16'h1900};

  // read-only offset calibration status
  localparam logic [6:0]  ADDR_OFS_STATUS = 7'h58;
  localparam int          OFS_DONE_LSB    = 13;

  // field positions
  localparam int FRAC_EN_POS      = 5;
  localparam int FRAC_ORDER_LSB   = 0;
  localparam int OUT_B_LSB        = 0;
  localparam int SYNC_MASK_POS    = 15;
  localparam int LOCK_KIND_POS    = 0;
  localparam int CH_DIV_LSB       = 6;
  localparam int WARM_POS         = 9;
  localparam int CHAIN_PD_POS     = 0;
  localparam int CHAIN_RST_POS    = 1;
  localparam int LOW_NOISE_AMP_POWER_DOWN_POS       = 2;
  localparam int IFA_PULLUP_EN_POS = 6;
  localparam int LO_PATH_SECTION_ENABLE_LSB   = 12;
  localparam int LO_ROUTE_LSB     = 0;
  localparam int SYNC_DRV1_POS    = 9;
  localparam int SYNC_DRV2_POS    = 10;
  localparam int SYNC_MIXLO_POS   = 11;
  localparam int STATE_CLOCK_SOURCE_SELECT_POS   = 0;
  localparam int EXTLO_DRV_LSB    = 1;
  localparam int LO_QUAD_LSB      = 4;
  localparam int EXTERNAL_LO_CLOCK_DIVIDE_EN_LSB = 6;
  localparam int LO_POLY_LSB      = 8;
  localparam int EXT_DIV_LSB      = 0;
  localparam int IF_CM_LSB        = 9;
  localparam int IFA_PULLUP_LSB   = 13;
  localparam int I_TRIG_POS       = 0;
  localparam int Q_TRIG_POS       = 1;
  localparam int OFS_CLK_DIV_LSB  = 6;

  // lock-detect kinds
  typedef enum logic [0:0] {
    LOCK_CAL_ONLY  = 1'b0,
    LOCK_CAL_VTUNE = 1'b1
  } lock_kind_e;

  // serial programming pins, all sampled on sys_clk
  typedef struct packed {
    logic csb_n;
    logic sck;
    logic sdi;
  } spi_pins_s;

  // configuration handed to the analog and synthesizer sections
  typedef struct packed {
    logic       frac_modulator_enable;
    logic [2:0] frac_modulator_order;
    logic [1:0] output_b_source_select;
    logic       sync_input_mask;
    lock_kind_e lock_detect_kind;
    logic [31:0] sync_settle_delay_count;
    logic [4:0] vco_channel_divider;
    logic       vco_cal_warm_start;
    logic [2:0] lo_path_section_enable;
    logic       ifa_pullup_enable;
    logic       low_noise_amp_power_down;
    logic       signal_chain_reset;
    logic       signal_chain_power_down;
    logic       sync_mixlo_loop;
    logic       sync_second_driver_enable;
    logic       sync_first_driver_enable;
    logic [5:0] lo_routing_select;
    logic [3:0] lo_polyphase_config;
    logic [1:0] state_clock_driver_select;
    logic [1:0] lo_quadrature_driver_config;
    logic [1:0] state_clock_driver_enable;
    logic       state_clock_source_select;
    logic [5:0] external_lo_clock_divide;
    logic [2:0] ifa_pullup_select;
    logic [3:0] if_output_common_mode_select;
    logic [9:0] offset_cal_clock_divide;
  } mixer_ctrl_s;

endpackage

// [rtl/synth_mixer_control_regs.sv]
// serial-programmed control and status register bank of the mixer synthesizer
`timescale 1ns/1ps

module synth_mixer_control_regs
  import mixer_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire spi_pins_s   spi_pins,
  output logic             spi_sdo,
  output mixer_ctrl_s      ctrl,
  input  wire logic        vco_cal_busy,
  input  wire logic        vtune_in_range,
  input  wire logic [15:0] lock_detect_hold_count,
  output logic             lock_detect,
  input  wire logic        fractional_mode,
  input  wire logic        phase_sync_enable,
  input  wire logic        sync_pin,
  output logic             sync_release,
  output logic             frac_modulator_restart,
  output logic             i_offset_cal_start,
  output logic             q_offset_cal_start,
  input  wire logic        i_offset_cal_done,
  input  wire logic        q_offset_cal_done
);

  logic [15:0]       regs_q [NUM_REGS];
  logic              sck_prev_q;
  logic [4:0]        bit_cnt_q;
  logic [FRAME_BITS-2:0] shift_in_q;
  logic              read_q;
  logic [15:0]       shift_out_q;
  logic              sdo_q;
  logic              sck_rise;
  logic              sck_fall;
  logic [FRAME_BITS-1:0] frame_now;
  logic              wr_en;
  logic [15:0]       rd_data;
  logic [1:0]        done_q;
  logic              frac_en_prev_q;
  logic              restart_q;
  logic [1:0]        trig_prev_q;
  logic              i_start_q;
  logic              q_start_q;
  logic [15:0]       hold_cnt_q;
  logic              lock_q;
  logic              cal_lock;
  logic              sync_prev_q;
  logic              sync_event;
  logic              settle_busy_q;
  logic [31:0]       settle_cnt_q;
  logic              release_q;

  // serial clock edges seen on sys_clk
  assign sck_rise  = spi_pins.sck & ~sck_prev_q & ~spi_pins.csb_n;
  assign sck_fall  = ~spi_pins.sck & sck_prev_q & ~spi_pins.csb_n;
  assign frame_now = {shift_in_q, spi_pins.sdi};
  assign wr_en     = sck_rise && (bit_cnt_q == DATA_LAST_BIT) && !read_q;

  // read mux; unmapped and reserved bits return zero
  always_comb
  begin
    rd_data = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (frame_now[ADDR_W-1:0] == REG_ADDR[i])
        rd_data = regs_q[i];
    end
    if (frame_now[ADDR_W-1:0] == ADDR_OFS_STATUS)
      rd_data = 16'(done_q) << OFS_DONE_LSB;
  end

  // serial frame receive and readback shift
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_prev_q  <= 1'b0;
      bit_cnt_q   <= 5'h00;
      shift_in_q  <= '0;
      read_q      <= 1'b0;
      shift_out_q <= 16'h0000;
      sdo_q       <= 1'b0;
    end
    else
    begin
      sck_prev_q <= spi_pins.sck;
      if (spi_pins.csb_n)
      begin
        bit_cnt_q <= 5'h00; // frame aborted or ended
        read_q    <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_in_q <= frame_now[FRAME_BITS-2:0];
        bit_cnt_q  <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == ADDR_LAST_BIT)
        begin
          read_q      <= frame_now[READ_FLAG_POS+1];
          shift_out_q <= rd_data;
        end
      end
      else if (sck_fall && read_q)
      begin
        sdo_q       <= shift_out_q[15];
        shift_out_q <= {shift_out_q[14:0], 1'b0};
      end
    end
  end

  // register storage with per-register writable masks
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET[i];
    end
    else if (wr_en)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (shift_in_q[DATA_W+ADDR_W-2:DATA_W-1] == REG_ADDR[i])
          regs_q[i] <= frame_now[DATA_W-1:0] & REG_MASK[i];
      end
    end
  end

  // modulator restart on enable rising edge
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frac_en_prev_q <= 1'b1;
      restart_q      <= 1'b0;
    end
    else
    begin
      frac_en_prev_q <= regs_q[IDX_FRAC_MOD][FRAC_EN_POS];
      restart_q      <= regs_q[IDX_FRAC_MOD][FRAC_EN_POS] & ~frac_en_prev_q;
    end
  end

  // offset calibration triggers and done status
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trig_prev_q <= 2'b00;
      i_start_q   <= 1'b0;
      q_start_q   <= 1'b0;
      done_q      <= 2'b00;
    end
    else
    begin
      trig_prev_q <= {regs_q[IDX_OFS_CTRL][Q_TRIG_POS], regs_q[IDX_OFS_CTRL][I_TRIG_POS]};
      i_start_q   <= regs_q[IDX_OFS_CTRL][I_TRIG_POS] & ~trig_prev_q[0];
      q_start_q   <= regs_q[IDX_OFS_CTRL][Q_TRIG_POS] & ~trig_prev_q[1];
      // a done pulse wins over the clear from a new start
      if (i_offset_cal_done)
        done_q[0] <= 1'b1;
      else if (i_start_q)
        done_q[0] <= 1'b0;
      if (q_offset_cal_done)
        done_q[1] <= 1'b1;
      else if (q_start_q)
        done_q[1] <= 1'b0;
    end
  end

  // lock indication: low in calibration and for the hold count after
  assign cal_lock = !vco_cal_busy && (hold_cnt_q == 16'h0000);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
    end
    else
    begin
      if (vco_cal_busy)
        hold_cnt_q <= lock_detect_hold_count;
      else if (hold_cnt_q != 16'h0000)
        hold_cnt_q <= hold_cnt_q - 16'h0001;
      if (lock_kind_e'(regs_q[IDX_LOCK_KIND][LOCK_KIND_POS]) == LOCK_CAL_VTUNE)
        lock_q <= cal_lock & vtune_in_range;
      else
        lock_q <= cal_lock;
    end
  end

  // sync pin masking and fractional settle delay before release
  assign sync_event = sync_pin & ~sync_prev_q & ~regs_q[IDX_SYNC_MASK][SYNC_MASK_POS];
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_prev_q   <= 1'b0;
      settle_busy_q <= 1'b0;
      settle_cnt_q  <= 32'h0000_0000;
      release_q     <= 1'b0;
    end
    else
    begin
      sync_prev_q <= sync_pin;
      release_q   <= 1'b0;
      if (settle_busy_q)
      begin
        if (settle_cnt_q == 32'h0000_0000)
        begin
          settle_busy_q <= 1'b0;
          release_q     <= 1'b1;
        end
        else
          settle_cnt_q <= settle_cnt_q - 32'h0000_0001;
      end
      else if (sync_event)
      begin
        if (fractional_mode && phase_sync_enable)
        begin
          settle_busy_q <= 1'b1;
          settle_cnt_q  <= {regs_q[IDX_SETTLE_HI], regs_q[IDX_SETTLE_LO]};
        end
        else
          release_q <= 1'b1;
      end
    end
  end

  // configuration fields straight from the register flops
  assign ctrl.frac_modulator_enable        = regs_q[IDX_FRAC_MOD][FRAC_EN_POS];
  assign ctrl.frac_modulator_order         = regs_q[IDX_FRAC_MOD][FRAC_ORDER_LSB +: 3];
  assign ctrl.output_b_source_select       = regs_q[IDX_OUT_B][OUT_B_LSB +: 2];
  assign ctrl.sync_input_mask              = regs_q[IDX_SYNC_MASK][SYNC_MASK_POS];
  assign ctrl.lock_detect_kind             =
    lock_kind_e'(regs_q[IDX_LOCK_KIND][LOCK_KIND_POS]);
  assign ctrl.sync_settle_delay_count      = {regs_q[IDX_SETTLE_HI], regs_q[IDX_SETTLE_LO]};
  assign ctrl.vco_channel_divider          = regs_q[IDX_CH_DIV][CH_DIV_LSB +: 5];
  assign ctrl.vco_cal_warm_start           = regs_q[IDX_WARM][WARM_POS];
  assign ctrl.lo_path_section_enable       = regs_q[IDX_CHAIN][LO_PATH_SECTION_ENABLE_LSB +: 3];
  assign ctrl.ifa_pullup_enable            = regs_q[IDX_CHAIN][IFA_PULLUP_EN_POS];
  assign ctrl.low_noise_amp_power_down     = regs_q[IDX_CHAIN][LOW_NOISE_AMP_POWER_DOWN_POS];
  assign ctrl.signal_chain_reset           = regs_q[IDX_CHAIN][CHAIN_RST_POS];
  assign ctrl.signal_chain_power_down      = regs_q[IDX_CHAIN][CHAIN_PD_POS];
  assign ctrl.sync_mixlo_loop              = regs_q[IDX_LO_ROUTE][SYNC_MIXLO_POS];
  assign ctrl.sync_second_driver_enable    = regs_q[IDX_LO_ROUTE][SYNC_DRV2_POS];
  assign ctrl.sync_first_driver_enable     = regs_q[IDX_LO_ROUTE][SYNC_DRV1_POS];
  assign ctrl.lo_routing_select            = regs_q[IDX_LO_ROUTE][LO_ROUTE_LSB +: 6];
  assign ctrl.lo_polyphase_config          = regs_q[IDX_LO_CLK][LO_POLY_LSB +: 4];
  assign ctrl.state_clock_driver_select    = regs_q[IDX_LO_CLK][EXTERNAL_LO_CLOCK_DIVIDE_EN_LSB +: 2];
  assign ctrl.lo_quadrature_driver_config  = regs_q[IDX_LO_CLK][LO_QUAD_LSB +: 2];
  assign ctrl.state_clock_driver_enable    = regs_q[IDX_LO_CLK][EXTLO_DRV_LSB +: 2];
  assign ctrl.state_clock_source_select    = regs_q[IDX_LO_CLK][STATE_CLOCK_SOURCE_SELECT_POS];
  assign ctrl.external_lo_clock_divide     = regs_q[IDX_EXT_DIV][EXT_DIV_LSB +: 6];
  assign ctrl.ifa_pullup_select            = regs_q[IDX_IF_BIAS][IFA_PULLUP_LSB +: 3];
  assign ctrl.if_output_common_mode_select = regs_q[IDX_IF_BIAS][IF_CM_LSB +: 4];
  assign ctrl.offset_cal_clock_divide      = regs_q[IDX_OFS_CTRL][OFS_CLK_DIV_LSB +: 10];

  // pulse and level outputs
  assign spi_sdo                = sdo_q;
  assign lock_detect            = lock_q;
  assign sync_release           = release_q;
  assign frac_modulator_restart = restart_q;
  assign i_offset_cal_start     = i_start_q;
  assign q_offset_cal_start     = q_start_q;

endmodule // synth_mixer_control_regs

// [sim/mixer_regs_monitor.sv]
// checker bound to the mixer control register bank
`timescale 1ns/1ps
module mixer_regs_monitor
  import mixer_regs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire spi_pins_s   spi_pins,
  input wire mixer_ctrl_s ctrl,
  input wire logic        vco_cal_busy,
  input wire logic        vtune_in_range,
  input wire logic [15:0] lock_detect_hold_count,
  input wire logic        lock_detect,
  input wire logic        fractional_mode,
  input wire logic        phase_sync_enable,
  input wire logic        sync_pin,
  input wire logic        sync_release,
  input wire logic        frac_modulator_restart,
  input wire logic        i_offset_cal_start,
  input wire logic        q_offset_cal_start
);
  logic [16:0] idle_q;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // idle cycles since the last calibration cycle, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      idle_q <= '1;
    else if (vco_cal_busy)
      idle_q <= '0;
    else if (idle_q != '1)
      idle_q <= idle_q + 17'h1;
  end
  AST_FRAC_RESTART: assert property (
    $rose(ctrl.frac_modulator_enable) |-> ##[0:1] frac_modulator_restart)
    else $error("modulator restart pulse missing");
  AST_RESTART_ONE: assert property (
    frac_modulator_restart |=> !frac_modulator_restart)
    else $error("modulator restart longer than one cycle");
  AST_LOCK_BUSY: assert property (
    vco_cal_busy |=> !lock_detect)
    else $error("lock high during calibration");
  AST_LOCK_HOLD_LOW: assert property (
    (idle_q != 17'h0 && idle_q < {1'b0, lock_detect_hold_count}) |-> !lock_detect)
    else $error("lock high inside hold count");
  AST_LOCK_HOLD_HIGH: assert property (
    (idle_q > {1'b0, lock_detect_hold_count} + 17'h2 && $past(reset_n)
     && ctrl.lock_detect_kind == LOCK_CAL_ONLY && $stable(ctrl.lock_detect_kind))
    |-> lock_detect)
    else $error("lock low after hold count");
  AST_LOCK_VTUNE: assert property (
    (ctrl.lock_detect_kind == LOCK_CAL_VTUNE && !vtune_in_range) |=> !lock_detect)
    else $error("lock high with tuning voltage out of range");
  AST_SYNC_PROMPT: assert property (
    ($rose(sync_pin) && !ctrl.sync_input_mask && !(fractional_mode && phase_sync_enable))
    |-> ##[1:2] sync_release)
    else $error("sync release missing");
  AST_SYNC_MASKED: assert property (
    (ctrl.sync_input_mask && $rose(sync_pin)) |-> ##1 !sync_release [*2])
    else $error("masked sync event released");
  AST_SYNC_SETTLE: assert property (
    ($rose(sync_pin) && !ctrl.sync_input_mask && fractional_mode && phase_sync_enable
     && ctrl.sync_settle_delay_count == 32'h0000000A)
    |-> !sync_release [*8] ##[4:5] sync_release)
    else $error("settle delayed release off time");
  AST_I_START_ONE: assert property (
    i_offset_cal_start |=> !i_offset_cal_start)
    else $error("I start pulse too long");
  AST_Q_START_ONE: assert property (
    q_offset_cal_start |=> !q_offset_cal_start)
    else $error("Q start pulse too long");
  AST_CTRL_QUIET: assert property (
    spi_pins.csb_n [*4] |=> $stable(ctrl))
    else $error("configuration changed without a frame");
endmodule // mixer_regs_monitor

bind synth_mixer_control_regs mixer_regs_monitor mixer_regs_monitor_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .spi_pins(spi_pins), .ctrl(ctrl),
  .vco_cal_busy(vco_cal_busy), .vtune_in_range(vtune_in_range),
  .lock_detect_hold_count(lock_detect_hold_count), .lock_detect(lock_detect),
  .fractional_mode(fractional_mode), .phase_sync_enable(phase_sync_enable),
  .sync_pin(sync_pin), .sync_release(sync_release),
  .frac_modulator_restart(frac_modulator_restart),
  .i_offset_cal_start(i_offset_cal_start), .q_offset_cal_start(q_offset_cal_start));

// [sim/spi_host_model.sv]
// serial host model driving programming frames into the register bank
`timescale 1ns/1ps
module spi_host_model
  import mixer_regs_pkg::*;
(
  input  wire logic sys_clk,
  output spi_pins_s spi_pins,
  input  wire logic spi_sdo
);
  // idle bus: deselected, clock low
  initial
    spi_pins = 3'b100;
  // one whole frame, msb first; sck 3 cycles low, 3 high
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
    output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = '0;
    @(posedge sys_clk);
    spi_pins.csb_n <= 1'b0;
    for (int k = 23; k >= 0; k--)
    begin
      @(posedge sys_clk);
      spi_pins.sdi <= f[k];
      spi_pins.sck <= 1'b0;
      repeat (3) @(posedge sys_clk);
      if (k < 16)
        q[k] = spi_sdo;  // bit shifted out after the previous fall
      spi_pins.sck <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    spi_pins <= '{csb_n: 1'b1, sck: 1'b0, sdi: ~f[0]};  // data line driven to the inverse of the last bit
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // spi_host_model

// [sim/tb.sv]
// self-checking bench for the mixer control register bank
`timescale 1ns/1ps
module tb;
  import mixer_regs_pkg::*;
  localparam logic [6:0] AT [14] = '{7'h2C, 7'h2E, 7'h3A, 7'h3B, 7'h45, 7'h46, 7'h4B,
    7'h4E, 7'h4F, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54};
  localparam logic [15:0] RT [14] = '{16'h0022, 16'h0001, 16'h8000, 16'h0001, 16'h0000,
    16'hC350, 16'h0000, 16'h0000, 16'h7000, 16'h000A, 16'h0000, 16'h0023, 16'h2000, 16'h1900};
  localparam logic [15:0] MT [14] = '{16'h0027, 16'h0003, 16'h8000, 16'h0001, 16'hFFFF,
    16'hFFFF, 16'h07C0, 16'h0200, 16'h7047, 16'h0E3F, 16'h0FF7, 16'h003F, 16'hFE00, 16'hFFC3};
  localparam logic [3:0] CM [4] = '{4'h0, 4'h3, 4'h5, 4'h9};
  logic        sys_clk, reset_n, spi_sdo, vco_cal_busy, vtune_in_range, lock_detect;
  logic        fractional_mode, phase_sync_enable, sync_pin, sync_release;
  logic        frac_modulator_restart, i_offset_cal_start, q_offset_cal_start;
  logic        i_offset_cal_done, q_offset_cal_done;
  logic [15:0] lock_detect_hold_count, rd_data, d;
  logic [15:0] exp_q [$];
  logic [15:0] dv [14];
  spi_pins_s   spi_pins;
  mixer_ctrl_s ctrl;
  int          n_mismatch, compares, cycles, n_rst, n_ist, n_qst, n_rel, seed;
  event        rd_done;

  synth_mixer_control_regs synth_mixer_control_regs_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .spi_pins(spi_pins), .spi_sdo(spi_sdo), .ctrl(ctrl),
    .vco_cal_busy(vco_cal_busy), .vtune_in_range(vtune_in_range),
    .lock_detect_hold_count(lock_detect_hold_count), .lock_detect(lock_detect),
    .fractional_mode(fractional_mode), .phase_sync_enable(phase_sync_enable),
    .sync_pin(sync_pin), .sync_release(sync_release),
    .frac_modulator_restart(frac_modulator_restart),
    .i_offset_cal_start(i_offset_cal_start), .q_offset_cal_start(q_offset_cal_start),
    .i_offset_cal_done(i_offset_cal_done), .q_offset_cal_done(q_offset_cal_done));
  spi_host_model spi_host_model_inst (.sys_clk(sys_clk), .spi_pins(spi_pins),
    .spi_sdo(spi_sdo));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    spi_host_model_inst.xfer(1'b1, a, 16'h0000, rd_data);
    -> rd_done;
  endtask
  task wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] unused;
    spi_host_model_inst.xfer(1'b0, a, v, unused);
  endtask
  task close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // readback watcher takes the oldest expected word
  always @(rd_done)
    chk("readback", {16'h0, rd_data}, {16'h0, exp_q.pop_front()});

  // pulse counters and run ceiling
  always @(posedge sys_clk)
  begin
    cycles++;
    n_rst += int'(frac_modulator_restart === 1'b1);
    n_ist += int'(i_offset_cal_start === 1'b1);
    n_qst += int'(q_offset_cal_start === 1'b1);
    n_rel += int'(sync_release === 1'b1);
    if (cycles == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    seed = 55;
    {vco_cal_busy, fractional_mode, phase_sync_enable, sync_pin} = 4'h0;
    {i_offset_cal_done, q_offset_cal_done, vtune_in_range} = 3'b001;
    lock_detect_hold_count = 16'h0004;
    cyc(5);
    reset_n <= 1'b1;
    for (int i = 0; i < 14; i++)
      rd(AT[i], RT[i]);
    rd(7'h58, 16'h0000);
    rd(7'h10, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 14; i++)
    begin
      d = 16'($random(seed));
      if (AT[i] == 7'h2C) d[5] = 1'b1;
      if (AT[i] == 7'h3A) d[15] = 1'b1;
      if (AT[i] == 7'h54) d[1:0] = 2'h0;
      if (AT[i] == 7'h53) d[12:9] = CM[d[1:0]];
      dv[i] = d;
      wr(AT[i], d);
      rd(AT[i], d & MT[i]);
    end
    wr(7'h58, 16'hFFFF);
    rd(7'h58, 16'h0000);
    chk("order", ctrl.frac_modulator_order, dv[0][2:0]);
    chk("out b", ctrl.output_b_source_select, dv[1][1:0]);
    chk("settle", ctrl.sync_settle_delay_count, {dv[4], dv[5]});
    chk("vco_channel_divider", ctrl.vco_channel_divider, dv[6][10:6]);
    chk("warm", ctrl.vco_cal_warm_start, dv[7][9]);
    chk("chain", {ctrl.low_noise_amp_power_down, ctrl.signal_chain_reset,
      ctrl.signal_chain_power_down}, dv[8][2:0]);
    chk("lo path", ctrl.lo_path_section_enable, dv[8][14:12]);
    chk("sync drv", {ctrl.sync_second_driver_enable, ctrl.sync_first_driver_enable},
      dv[9][10:9]);
    chk("lo route", ctrl.lo_routing_select, dv[9][5:0]);
    chk("poly", ctrl.lo_polyphase_config, dv[10][11:8]);
    chk("quad", ctrl.lo_quadrature_driver_config, dv[10][5:4]);
    chk("sm clk", ctrl.state_clock_source_select, dv[10][0]);
    chk("ext div", ctrl.external_lo_clock_divide, dv[11][5:0]);
    chk("common mode", ctrl.if_output_common_mode_select, dv[12][12:9]);
    chk("ofs div", ctrl.offset_cal_clock_divide, dv[13][15:6]);
    chk("mod en", ctrl.frac_modulator_enable, 1'b1);
    chk("mask", ctrl.sync_input_mask, 1'b1);
    chk("kind", ctrl.lock_detect_kind, dv[3][0]);
    chk("extras", {ctrl.ifa_pullup_enable, ctrl.sync_mixlo_loop,
      ctrl.state_clock_driver_select, ctrl.state_clock_driver_enable, ctrl.ifa_pullup_select},
      {dv[8][6], dv[9][11], dv[10][7:6], dv[10][2:1], dv[12][15:13]});
    $display("test random write readback done");
    // modulator restart by low then high enable
    wr(7'h2C, 16'h0002);
    chk("no restart", n_rst, 0);
    wr(7'h2C, 16'h0022);
    chk("restart", n_rst, 1);
    $display("test modulator restart done");
    // offset calibration triggers, status and retrigger
    wr(7'h54, 16'h1901);
    chk("i start", n_ist, 1);
    @(posedge sys_clk) i_offset_cal_done <= 1'b1;
    @(posedge sys_clk) i_offset_cal_done <= 1'b0;
    rd(7'h58, 16'h2000);
    wr(7'h54, 16'h1903);
    chk("q start", n_qst, 1);
    chk("i held", n_ist, 1);
    @(posedge sys_clk) q_offset_cal_done <= 1'b1;
    @(posedge sys_clk) q_offset_cal_done <= 1'b0;
    rd(7'h58, 16'h6000);
    wr(7'h54, 16'h1902);
    wr(7'h54, 16'h1903);
    chk("i retrigger", n_ist, 2);
    rd(7'h58, 16'h4000);
    $display("test offset calibration done");
    // lock indication around a calibration
    wr(7'h3B, 16'h0000);
    @(posedge sys_clk) vco_cal_busy <= 1'b1;
    cyc(6);
    vco_cal_busy <= 1'b0;
    cyc(2);
    chk("lock hold", lock_detect, 1'b0);
    cyc(8);
    chk("lock cal", lock_detect, 1'b1);
    wr(7'h3B, 16'h0001);
    vtune_in_range <= 1'b0;
    cyc(3);
    chk("lock vtune", lock_detect, 1'b0);
    vtune_in_range <= 1'b1;
    cyc(3);
    chk("lock both", lock_detect, 1'b1);
    $display("test lock detect done");
    // sync events: prompt, settle delayed, masked
    wr(7'h3A, 16'h0000);
    wr(7'h45, 16'h0000);
    wr(7'h46, 16'h000A);
    wr(7'h50, 16'h060A);
    for (int m = 0; m < 3; m++)
    begin
      fractional_mode <= (m == 1);
      phase_sync_enable <= (m < 2);
      if (m == 2) wr(7'h3A, 16'h8000);
      cyc(2);
      sync_pin <= 1'b1;
      cyc(3);
      sync_pin <= 1'b0;
      cyc(14);
      chk("releases", n_rel, (m == 0) ? 1 : 2);
    end
    $display("test sync release done");
    cyc(2);
    close_out();
  end
endmodule // tb
